//--- rtl/lid_decoder.sv
// Instruction decoder and executor with its display and pattern RAMs.
// Assumes the host link clock is unrelated to sys_clk and may stop between frames;
// serial bit framing is done outside and arrives here as whole bytes.
`timescale 1ns/1ns
`default_nettype none

module lid_decoder #(
    parameter int INIT_BUSY_CYCLES = lid_pkg::INIT_CYCLES
) (
    input wire logic sys_clk,
    input wire logic rst,
    // Host link side
    input wire logic link_clk,
    input wire logic link_frame_start,
    input wire logic link_byte_stb,
    input wire logic [7:0] link_byte,
    input wire logic reg_select_line,
    input wire logic link_rw,
    input wire logic serial_mode,
    output logic link_ready,
    // Read answers, core domain
    output logic [7:0] host_rdata,
    output logic host_rdata_valid,
    // Configuration and state toward the display drivers
    output logic busy_flag,
    output logic [6:0] address_counter,
    output logic pattern_ram_sel,
    output logic display_enable,
    output logic cursor_enable,
    output logic blink_enable,
    output logic interface_width,
    output logic [1:0] line_mode,
    output logic vgen_ctrl,
    output logic [6:0] display_shift,
    output logic step_up,
    output logic shift_on_write,
    input wire logic [6:0] scan_addr,
    output logic [7:0] scan_char
);

    // Power-on busy; must outlast the clear walk
    localparam logic [17:0] INIT_CNT = 18'(INIT_BUSY_CYCLES);

    // Link state on link_clk
    lid_pkg::lid_link_s l;
    lid_pkg::lid_link_s next_l;

    // Core state on sys_clk
    lid_pkg::lid_core_s c;
    lid_pkg::lid_core_s next_c;
    logic [1:0] link_rst_sync;
    logic link_rst;

    // Depths first, the arrays below need them
    localparam int DISP_RAM_DEPTH_W = lid_pkg::DISP_RAM_DEPTH;
    localparam int PAT_RAM_DEPTH_W = lid_pkg::PAT_RAM_DEPTH;

    // Character and glyph storage
    logic [7:0] display_ram [DISP_RAM_DEPTH_W];
    logic [7:0] pattern_ram [PAT_RAM_DEPTH_W];

    // One write port: clear walk or data write
    logic disp_we;
    logic pat_we;
    logic [6:0] ram_addr;
    logic [7:0] ram_wdata;

    // Counter step, wraps over the seven address bits
    // Shared by counter and display shift
    function automatic logic [6:0] lid_step(input logic [6:0] v, input logic up);
        lid_step = up ? 7'(v + 7'h01) : 7'(v - 7'h01);
    endfunction

    // Reset carried into the link domain; only takes effect on link edges
    always_ff @(posedge link_clk) begin
        link_rst_sync <= {link_rst_sync[0], rst};
    end
    assign link_rst = link_rst_sync[1];

    // Link side: parse serial control bytes, fill the holding registers
    always_comb begin
        next_l = l;

        // Ack toggle crosses on three flops
        next_l.ack_sync = {l.ack_sync[1:0], c.ack};
        if (l.ack_sync[1] == l.ack_sync[2]) begin
            next_l.ack_seen = l.ack_sync[2];
        end

        // New frame opens with a control byte
        if (link_frame_start) begin
            next_l.ser_state = lid_pkg::LID_EXPECT_CTL;
        end
        if (link_byte_stb) begin
            if (serial_mode && l.ser_state == lid_pkg::LID_EXPECT_CTL) begin
                // Control byte: continuation, select, direction on top bits
                next_l.ser_rs = link_byte[6];
                next_l.ser_rw = link_byte[5];
                next_l.ser_state = link_byte[7] ? lid_pkg::LID_DATA_ONCE
                                                : lid_pkg::LID_DATA_STREAM;
            end else if (l.req == l.ack_seen) begin
                next_l.hold_rs = serial_mode ? l.ser_rs : reg_select_line;
                next_l.hold_rw = serial_mode ? l.ser_rw : link_rw;
                next_l.hold_serial = serial_mode;
                // Separate latches for commands and data
                if (serial_mode ? l.ser_rs : reg_select_line) begin
                    next_l.data_holding_reg = link_byte;
                end else begin
                    next_l.instruction_holding_reg = link_byte;
                end

                // Toggle; core echoes it as ack
                next_l.req = ~l.req;
                if (serial_mode && l.ser_state == lid_pkg::LID_DATA_ONCE) begin
                    next_l.ser_state = lid_pkg::LID_EXPECT_CTL;
                end
            end
        end
    end

    // Link state register
    always_ff @(posedge link_clk) begin
        if (link_rst) begin
            l <= '0;
        end else begin
            l <= next_l;
        end
    end

    // Holding registers stay put until the core has taken them
    assign link_ready = (l.req == l.ack_seen);

    // Core: synchronise the request, decode and execute
    always_comb begin
        logic take;
        logic pair;
        logic do_exec;
        logic [7:0] b;
        logic [7:0] cmd;
        logic [17:0] cyc;

        // Defaults: no write, state held
        take = 1'b0;
        pair = 1'b0;
        do_exec = 1'b0;
        b = 8'h00;
        cmd = 8'h00;
        cyc = lid_pkg::CYC_NOP;
        next_c = c;
        disp_we = 1'b0;
        pat_we = 1'b0;
        ram_addr = c.address_counter;
        ram_wdata = 8'h00;
        next_c.rvalid = 1'b0;

        // Request toggle crosses on three flops
        next_c.req_sync = {c.req_sync[1:0], l.req};
        // Scan port for the row drivers
        next_c.scan_char = display_ram[scan_addr];

        // Busy down-counter
        if (c.busy_flag) begin
            next_c.cnt = 18'(c.cnt - 18'h00001);
            if (c.cnt == 18'h00001) begin
                next_c.busy_flag = 1'b0;
            end
        end

        // Clear walks every location, one per cycle, inside its busy time
        if (c.clearing) begin
            disp_we = 1'b1;
            ram_addr = c.clr_idx;
            ram_wdata = lid_pkg::SPACE_CODE;
            // Last location ends the walk
            next_c.clr_idx = 7'(c.clr_idx + 7'h01);
            if (c.clr_idx == lid_pkg::CLEAR_LAST) begin
                next_c.clearing = 1'b0;
            end
        end

        // Change counts once second and third stages agree
        if (c.req_sync[1] == c.req_sync[2] && c.req_sync[2] != c.seen) begin
            take = 1'b1;
            next_c.seen = c.req_sync[2];
            next_c.ack = c.req_sync[2];
        end

        // Byte from the register the host chose
        if (take) begin
            b = l.hold_rs ? l.data_holding_reg : l.instruction_holding_reg;
            // Nibble pairing only on a 4-bit parallel write
            pair = !l.hold_rw && !l.hold_serial && !c.interface_width;
            cmd = pair ? {c.nib_hi, b[7:4]} : b;
            if (!l.hold_rs && l.hold_rw) begin
                // Status read always executes, costs nothing
                next_c.rdata = {c.busy_flag, c.address_counter};
                next_c.rvalid = 1'b1;
            end else if (c.busy_flag) begin
                // Everything else is dropped while busy
                next_c.nib_have = 1'b0;
            end else if (pair && !c.nib_have) begin
                next_c.nib_hi = b[7:4];
                next_c.nib_have = 1'b1;
            end else begin
                do_exec = 1'b1;
                next_c.nib_have = 1'b0;
            end
        end

        if (do_exec && !l.hold_rs) begin
            // Highest set bit selects the instruction
            cyc = lid_pkg::CYC_STD;
            unique casez (cmd)
                8'b1???????: begin
                    next_c.address_counter = cmd[6:0];
                    next_c.cg_sel = 1'b0;
                end
                8'b01??????: begin
                    // Bit 6 of the counter is kept
                    next_c.address_counter = {c.address_counter[6], cmd[5:0]};
                    next_c.cg_sel = 1'b1;
                end
                8'b001?????: begin
                    next_c.interface_width = cmd[4];
                    next_c.lines = cmd[3:2];
                    next_c.vgen = cmd[1];
                end
                8'b0001????: begin
                    // Bit 3 picks display shift or cursor move, bit 2 right
                    if (cmd[3]) begin
                        next_c.shift = lid_step(c.shift, !cmd[2]);
                    end else begin
                        next_c.address_counter = lid_step(c.address_counter, cmd[2]);
                    end
                end
                8'b00001???: begin
                    next_c.disp_on = cmd[2];
                    next_c.cur_on = cmd[1];
                    next_c.blink_on = cmd[0];
                end
                8'b000001??: begin
                    next_c.step_up = cmd[1];
                    next_c.shift_on_write = cmd[0];
                end
                8'b0000001?: begin
                    next_c.address_counter = 7'h00;
                    next_c.cg_sel = 1'b0;
                    next_c.shift = 7'h00;
                end
                8'b00000001: begin
                    cyc = lid_pkg::CYC_CLEAR;
                    next_c.clearing = 1'b1;
                    next_c.clr_idx = 7'h00;
                    next_c.address_counter = 7'h00;
                    next_c.cg_sel = 1'b0;
                    next_c.shift = 7'h00;
                    next_c.step_up = 1'b1;
                end
                8'b00000000: begin
                    cyc = lid_pkg::CYC_NOP;
                end
            endcase
        end else if (do_exec && !l.hold_rw) begin
            // Data write at the counter, then step
            cyc = lid_pkg::CYC_STD;
            ram_addr = c.address_counter;
            ram_wdata = cmd;
            disp_we = !c.cg_sel;
            pat_we = c.cg_sel;
            next_c.address_counter = lid_step(c.address_counter, c.step_up);
            // Pattern writes never shift
            if (!c.cg_sel && c.shift_on_write) begin
                next_c.shift = lid_step(c.shift, c.step_up);
            end
        end else if (do_exec) begin
            // Data read at the counter, then step
            cyc = lid_pkg::CYC_STD;
            next_c.rdata = c.cg_sel ? pattern_ram[c.address_counter[5:0]]
                                    : display_ram[c.address_counter];
            next_c.rvalid = 1'b1;
            next_c.address_counter = lid_step(c.address_counter, c.step_up);
        end

        // Busy raised on acceptance for the instruction's length
        if (cyc != lid_pkg::CYC_NOP) begin
            next_c.busy_flag = 1'b1;
            next_c.cnt = cyc;
        end

        // Last, so reset overrides every path
        if (rst) begin
            next_c = '0;
            next_c.busy_flag = 1'b1;
            next_c.cnt = INIT_CNT;
            next_c.clearing = 1'b1;
            next_c.interface_width = lid_pkg::RST_WIDTH;
            next_c.lines = lid_pkg::RST_LINES;
            next_c.vgen = lid_pkg::RST_VGEN;
            next_c.step_up = lid_pkg::RST_STEP_UP;
            next_c.shift_on_write = lid_pkg::RST_SHIFT_ON_WRITE;
            disp_we = 1'b0;
            pat_we = 1'b0;
        end
    end

    // Core state register
    always_ff @(posedge sys_clk) begin
        c <= next_c;
    end

    // RAM arrays; no reset, the power-on clear fills the display RAM
    always_ff @(posedge sys_clk) begin
        if (disp_we) begin
            display_ram[ram_addr] <= ram_wdata;
        end
        // Six address bits only
        if (pat_we) begin
            pattern_ram[ram_addr[5:0]] <= ram_wdata;
        end
    end

    // Read answers straight from flops
    assign host_rdata = c.rdata;
    assign host_rdata_valid = c.rvalid;

    // State toward the display drivers
    assign busy_flag = c.busy_flag;
    assign address_counter = c.address_counter;
    assign pattern_ram_sel = c.cg_sel;
    assign display_enable = c.disp_on;
    assign cursor_enable = c.cur_on;
    assign blink_enable = c.blink_on;
    assign interface_width = c.interface_width;
    assign line_mode = c.lines;
    assign vgen_ctrl = c.vgen;
    assign display_shift = c.shift;
    assign step_up = c.step_up;
    assign shift_on_write = c.shift_on_write;
    assign scan_char = c.scan_char;

endmodule

`default_nettype wire

//--- rtl/lid_pkg.sv
// Constants, states and state records for the character LCD instruction decoder.
// Assumes one core clock standing in for the display oscillator, plus a host link clock.
package lid_pkg;

    // Execution lengths in core clock cycles
    localparam logic [17:0] CYC_NOP = 18'h00000;
    localparam logic [17:0] CYC_CLEAR = 18'h000a5;
    localparam logic [17:0] CYC_STD = 18'h00003;

    // Power-on busy time: 2 ms at the core clock rate
    localparam int INIT_TIME_US = 2000;
    localparam int CLK_FREQ_MHZ = 100;
    localparam int INIT_CYCLES = INIT_TIME_US * CLK_FREQ_MHZ;

    localparam logic [7:0] SPACE_CODE = 8'h20;
    localparam logic [6:0] CLEAR_LAST = 7'h7f;
    localparam int DISP_RAM_DEPTH = 128;
    localparam int PAT_RAM_DEPTH = 64;

    // Values after reset
    localparam logic RST_WIDTH = 1'b1;
    localparam logic [1:0] RST_LINES = 2'h0;
    localparam logic RST_VGEN = 1'b0;
    localparam logic RST_STEP_UP = 1'b1;
    localparam logic RST_SHIFT_ON_WRITE = 1'b0;

    // Serial link byte expectation
    typedef enum logic [1:0] {
        LID_EXPECT_CTL = 2'b00,
        LID_DATA_ONCE = 2'b01,
        LID_DATA_STREAM = 2'b10
    } lid_ser_e;

    typedef struct packed {
        logic [2:0] ack_sync;
        logic ack_seen;
        logic req;
        logic hold_rs;
        logic hold_rw;
        logic hold_serial;
        logic [7:0] instruction_holding_reg;
        logic [7:0] data_holding_reg;
        lid_ser_e ser_state;
        logic ser_rs;
        logic ser_rw;
    } lid_link_s;

    typedef struct packed {
        logic [2:0] req_sync;
        logic seen;
        logic ack;
        logic busy_flag;
        logic [17:0] cnt;
        logic clearing;
        logic [6:0] clr_idx;
        logic [6:0] address_counter;
        logic cg_sel;
        logic step_up;
        logic shift_on_write;
        logic disp_on;
        logic cur_on;
        logic blink_on;
        logic interface_width;
        logic [1:0] lines;
        logic vgen;
        logic [6:0] shift;
        logic nib_have;
        logic [3:0] nib_hi;
        logic [7:0] rdata;
        logic rvalid;
        logic [7:0] scan_char;
    } lid_core_s;

endpackage

//--- rtl/lid_pkg_unused_guard.sv
`timescale 1ns/1ns

//--- tb/lid_decoder_sva.sv
// Checker for lid_decoder: busy timing, read answers and state at rest.
// Assumes it is bound to lid_decoder and sees only that module's ports.
`timescale 1ns/1ns
`default_nettype none

module lid_decoder_sva #(
    parameter int INIT_BUSY_CYCLES = 200
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic link_clk,
    input wire logic link_ready,
    input wire logic [7:0] host_rdata,
    input wire logic host_rdata_valid,
    input wire logic busy_flag,
    input wire logic [6:0] address_counter,
    input wire logic pattern_ram_sel,
    input wire logic display_enable,
    input wire logic cursor_enable,
    input wire logic blink_enable,
    input wire logic interface_width,
    input wire logic [1:0] line_mode,
    input wire logic vgen_ctrl,
    input wire logic [6:0] display_shift,
    input wire logic step_up,
    input wire logic shift_on_write
);
    logic [17:0] busy_len;
    logic len_ok;
    logic [23:0] cfg;

    // Length of the running busy period, zero while idle
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            busy_len <= 18'h00000;
        end else if (busy_flag) begin
            busy_len <= busy_len + 18'h00001;
        end else begin
            busy_len <= 18'h00000;
        end
    end

    // Power-on period counted loosely: its exact start depends on reset sync
    assign len_ok = busy_len == 18'h00003 || busy_len == 18'h000a5
        || busy_len >= INIT_BUSY_CYCLES - 2;
    assign cfg = {address_counter, pattern_ram_sel, display_enable, cursor_enable,
        blink_enable, interface_width, line_mode, vgen_ctrl, display_shift, step_up,
        shift_on_write};

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);

    sequence seq_busy_run;
        busy_flag [*3];
    endsequence
    sequence seq_idle_pair;
        !busy_flag ##1 !busy_flag;
    endsequence

    AST_BUSY_HOLD: assert property ($rose(busy_flag) |-> seq_busy_run)
        else $error("busy shorter than three cycles");
    AST_BUSY_LEN: assert property ($fell(busy_flag) |-> len_ok)
        else $error("busy period of unexpected length");
    AST_CLEAR_DONE: assert property ($fell(busy_flag) && busy_len == 18'h000a5 |->
        address_counter == 7'h00 && step_up && display_shift == 7'h00)
        else $error("clear left counter, shift or direction wrong");
    AST_IDLE_STABLE: assert property (seq_idle_pair |-> $stable(cfg))
        else $error("state changed without execution");
    AST_READ_PULSE: assert property (host_rdata_valid |=> !host_rdata_valid)
        else $error("read valid longer than one cycle");
    AST_READ_HOLD: assert property (!host_rdata_valid |-> $stable(host_rdata))
        else $error("read data moved without an answer");
    AST_RESET_STATE: assert property (@(posedge sys_clk) disable iff (1'b0) rst |=>
        busy_flag && address_counter == 7'h00 && interface_width && step_up && !display_enable)
        else $error("state after reset wrong");
    AST_READY_BACK: assert property (@(posedge link_clk) disable iff (rst)
        $fell(link_ready) |-> ##[1:12] link_ready)
        else $error("holding registers not freed in time");
endmodule

bind lid_decoder lid_decoder_sva #(.INIT_BUSY_CYCLES(INIT_BUSY_CYCLES)) u_lid_decoder_sva (
    .sys_clk(sys_clk), .rst(rst), .link_clk(link_clk), .link_ready(link_ready),
    .host_rdata(host_rdata), .host_rdata_valid(host_rdata_valid), .busy_flag(busy_flag),
    .address_counter(address_counter), .pattern_ram_sel(pattern_ram_sel),
    .display_enable(display_enable), .cursor_enable(cursor_enable),
    .blink_enable(blink_enable), .interface_width(interface_width), .line_mode(line_mode),
    .vgen_ctrl(vgen_ctrl), .display_shift(display_shift), .step_up(step_up),
    .shift_on_write(shift_on_write));

`default_nettype wire

//--- tb/lid_host_model.sv
// Host model on the decoder's link side: one byte per handshake.
// Assumes link_ready from the decoder; clk_hold keeps the clock up during reset.
`timescale 1ns/1ns
`default_nettype none

module lid_host_model (
    input wire logic clk_hold,
    input wire logic link_ready,
    output logic link_clk,
    output logic link_frame_start,
    output logic link_byte_stb,
    output logic [7:0] link_byte,
    output logic reg_select_line,
    output logic link_rw,
    output logic serial_mode
);
    logic run = 1'b0;
    int timeouts = 0;

    // Idle levels at time zero
    initial begin
        link_clk = 1'b0;
        link_frame_start = 1'b0;
        link_byte_stb = 1'b0;
        link_byte = 8'h5a;
        reg_select_line = 1'b0;
        link_rw = 1'b0;
        serial_mode = 1'b0;
    end

    // 15 ns link clock, still between frames so idle logic is not exercised
    always begin
        #7;
        link_clk = run || clk_hold;
        #8;
        link_clk = 1'b0;
    end

    // Bounded wait for free holding registers
    task automatic wait_ready();
        int n;
        n = 0;
        while (link_ready !== 1'b1 && n < 60) begin
            @(posedge link_clk);
            n++;
        end
        if (n >= 60) timeouts++;
    endtask

    // Next request only once the previous one is released
    task automatic send(input logic s, input logic sel, input logic dir, input logic [7:0] b);
        run = 1'b1;
        // Two edges first: link reset releases only on a running clock
        repeat (2) @(posedge link_clk);
        wait_ready();
        link_byte_stb <= 1'b1;
        link_byte <= b;
        reg_select_line <= sel;
        link_rw <= dir;
        serial_mode <= s;
        @(posedge link_clk);
        link_byte_stb <= 1'b0;
        link_byte <= ~b;
        @(posedge link_clk);
        wait_ready();
        run = 1'b0;
    endtask

    // Frame start: the next byte is a control byte
    task automatic frame();
        run = 1'b1;
        @(posedge link_clk);
        link_frame_start <= 1'b1;
        @(posedge link_clk);
        link_frame_start <= 1'b0;
        @(posedge link_clk);
        run = 1'b0;
    endtask
endmodule

`default_nettype wire

//--- tb/tb_lcd_instruction_decoder.sv
// Self-checking bench for the instruction decoder against a reference model.
// Assumes lid_host_model on the link side and the bound checker.
`timescale 1ns/1ns
`default_nettype none

module tb_lcd_instruction_decoder;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic [6:0] scan_addr = 7'h00;
    wire logic link_clk, fs, stb, rs, rw, ser;
    wire logic [7:0] lbyte;
    logic [7:0] rdata, scan_char, r;
    logic rdy, valid, busy, cg, de, ce, be, wd, vg, up, sow;
    logic [6:0] ac, shf;
    logic [1:0] lines;
    logic smode = 1'b0;
    int miscompares = 0, num_checks = 0, busy_cycles = 0;
    int m_ac = 0, m_cg = 0, m_up = 1, m_sow = 0, m_shift = 0, m_disp = 0, m_fun = 8;
    int dram [128];
    int cram [64];
    logic [7:0] rq [$];
    logic [31:0] lfsr = 32'h00010128;

    always #5 sys_clk = ~sys_clk;

    lid_decoder #(.INIT_BUSY_CYCLES(200)) u_lid_decoder (
        .sys_clk(sys_clk), .rst(rst), .link_clk(link_clk), .link_frame_start(fs),
        .link_byte_stb(stb), .link_byte(lbyte), .reg_select_line(rs), .link_rw(rw),
        .serial_mode(ser), .link_ready(rdy), .host_rdata(rdata), .host_rdata_valid(valid),
        .busy_flag(busy), .address_counter(ac), .pattern_ram_sel(cg), .display_enable(de),
        .cursor_enable(ce), .blink_enable(be), .interface_width(wd), .line_mode(lines),
        .vgen_ctrl(vg), .display_shift(shf), .step_up(up), .shift_on_write(sow),
        .scan_addr(scan_addr), .scan_char(scan_char));
    lid_host_model u_lid_host_model (.clk_hold(rst), .link_ready(rdy), .link_clk(link_clk),
        .link_frame_start(fs), .link_byte_stb(stb), .link_byte(lbyte),
        .reg_select_line(rs), .link_rw(rw), .serial_mode(ser));

    // Read answers and busy time collected at every core edge
    always @(posedge sys_clk) begin
        if (valid === 1'b1) rq.push_back(rdata);
        if (busy === 1'b1) busy_cycles++;
    end

    function automatic logic [7:0] rnd();
        lfsr = lfsr[0] ? (lfsr >> 1) ^ 32'h80200003 : lfsr >> 1;
        return lfsr[7:0];
    endfunction

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic summarize();
        miscompares += u_lid_host_model.timeouts;
        $display("checks %0d miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic wait_idle();
        int n;
        n = 0;
        while (busy !== 1'b0 && n < 600) begin
            @(negedge sys_clk);
            n++;
        end
        if (n >= 600) begin
            miscompares++;
            summarize();
        end
    endtask

    // Reference: commands decoded by their highest set bit, except 8'h03, taken as a clear
    task automatic model_cmd(input logic [7:0] b);
        if (b[7]) begin
            m_ac = b[6:0];
            m_cg = 0;
        end else if (b[6]) begin
            m_ac = (m_ac & 64) | b[5:0];
            m_cg = 1;
        end else if (b[5]) m_fun = b[4:1];
        else if (b[4] && b[3]) m_shift = (m_shift + (b[2] ? 127 : 1)) % 128;
        else if (b[4]) m_ac = (m_ac + (b[2] ? 1 : 127)) % 128;
        else if (b[3]) m_disp = b[2:0];
        else if (b[2]) begin
            m_up = b[1];
            m_sow = b[0];
        end else if (b[1] || b[0]) begin
            m_ac = 0;
            m_shift = 0;
            m_cg = 0;
            if (b[0]) m_up = 1;
            if (b[0]) foreach (dram[i]) dram[i] = 32;
        end
    endtask

    // Reference: data access steps the counter, display writes may shift
    task automatic model_data(input logic [7:0] b, input logic wr);
        int st;
        st = m_up ? 1 : 127;
        if (wr && m_cg) cram[m_ac % 64] = b;
        if (wr && !m_cg) dram[m_ac] = b;
        if (wr && !m_cg && m_sow) m_shift = (m_shift + st) % 128;
        m_ac = (m_ac + st) % 128;
    endtask

    task automatic state_chk();
        check("counter", {cg, ac}, m_cg * 128 + m_ac);
        check("entry", {up, sow, shf}, m_up * 256 + m_sow * 128 + m_shift);
        check("display", {de, ce, be}, m_disp);
        check("function", {wd, lines, vg}, m_fun);
    endtask

    task automatic scan_chk(input logic [7:0] a);
        @(negedge sys_clk);
        scan_addr = a[6:0];
        @(negedge sys_clk);
        check("scan", scan_char, dram[a[6:0]]);
    endtask

    // One transfer while idle, then timing, answer and state compared
    task automatic xfer(input logic sel, input logic dir, input logic [7:0] b);
        int exp, cyc, b0;
        exp = sel ? (m_cg ? cram[m_ac % 64] : dram[m_ac]) : m_ac;
        cyc = (!sel && (dir || b == 8'h00)) ? 0 : ((!sel && b == 8'h01) ? 165 : 3);
        b0 = busy_cycles;
        rq.delete();
        u_lid_host_model.send(smode, sel, dir, b);
        wait_idle();
        check("busy cycles", busy_cycles - b0, cyc);
        if (dir) check("read", rq.size() == 1 ? 32'(rq[0]) : 'x, exp);
        if (sel) model_data(b, !dir);
        else if (!dir) model_cmd(b);
        state_chk();
    endtask

    task automatic cmd(input logic [7:0] b);
        xfer(1'b0, 1'b0, b);
    endtask
    task automatic dat(input logic [7:0] b);
        xfer(1'b1, 1'b0, b);
    endtask
    task automatic ctl(input logic [7:0] b);
        u_lid_host_model.frame();
        u_lid_host_model.send(1'b1, 1'b0, 1'b0, b);
    endtask

    // Run-length guard
    initial begin
        repeat (100000) @(posedge sys_clk);
        miscompares++;
        summarize();
    end

    initial begin
        foreach (dram[i]) dram[i] = 32;
        foreach (cram[i]) cram[i] = 0;
        repeat (4) @(negedge sys_clk);
        rst = 1'b0;
        u_lid_host_model.send(1'b0, 1'b0, 1'b1, 8'h00);
        check("init status", rq.size() == 1 ? 32'(rq[0][7]) : 'x, 1);
        wait_idle();
        state_chk();
        for (int i = 0; i < 3; i++) scan_chk(rnd());
        $display("test power-on done");
        for (int i = 0; i < 8; i++) cmd(8'h08 | 8'(i));
        for (int i = 0; i < 8; i++) cmd(8'h30 | 8'(i * 2));
        for (int i = 0; i < 4; i++) cmd(8'h10 | 8'(i * 4));
        cmd(8'h00);
        $display("test settings done");
        for (int k = 0; k < 2; k++) begin
            r = rnd();
            cmd(8'h80 | r);
            cmd(k ? 8'h05 : 8'h07);
            for (int i = 0; i < 3; i++) dat(rnd());
            scan_chk(r);
            cmd(8'h80 | r);
            for (int i = 0; i < 3; i++) xfer(1'b1, 1'b1, 8'h00);
        end
        cmd(8'h02);
        xfer(1'b0, 1'b1, 8'h00);
        cmd(8'h06);
        r = rnd() & 8'h1f;
        cmd(8'h40 | r);
        dat(rnd());
        dat(rnd());
        cmd(8'h40 | r);
        xfer(1'b1, 1'b1, 8'h00);
        xfer(1'b1, 1'b1, 8'h00);
        $display("test ram access done");
        u_lid_host_model.send(1'b0, 1'b0, 1'b0, 8'h01);
        u_lid_host_model.send(1'b0, 1'b0, 1'b0, 8'h08);
        rq.delete();
        u_lid_host_model.send(1'b0, 1'b0, 1'b1, 8'h00);
        check("busy status", rq.size() == 1 ? 32'(rq[0][7]) : 'x, 1);
        wait_idle();
        model_cmd(8'h01);
        state_chk();
        scan_chk(rnd());
        $display("test busy refusal done");
        smode = 1'b1;
        ctl(8'hc0);
        dat(rnd());
        u_lid_host_model.send(1'b1, 1'b0, 1'b0, 8'h00);
        cmd(8'h20);
        ctl(8'h40);
        dat(rnd());
        dat(rnd());
        ctl(8'h20);
        xfer(1'b0, 1'b1, 8'h00);
        ctl(8'h00);
        cmd(8'h30);
        smode = 1'b0;
        cmd(8'h20);
        // 4-bit parallel: one command as two nibbles
        u_lid_host_model.send(1'b0, 1'b0, 1'b0, 8'h30);
        u_lid_host_model.send(1'b0, 1'b0, 1'b0, 8'h00);
        wait_idle();
        model_cmd(8'h30);
        state_chk();
        cmd(8'h01);
        scan_chk(rnd());
        $display("test serial done");
        summarize();
    end
endmodule

`default_nettype wire
